// ### verilog/pbh_host_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbh_map.svh"
// What this block does
// - A bus address is the low six bits of the request, 0 to 63.
// - A checked request above 65535 gives an error and no bus cycle.
// - A checked read waits for write done, drives the address, settles, samples.
// - A checked write waits for write done, drives address, data, R/W, strobe.
// - The active-low bus busy line reads back as a status bit.
// - A writable control bit drives the active-low bus clear line.
// - The 64 bus addresses appear in a memory window at a fixed base.
// - Window accesses skip the done check and settling; reads need two tries.
// - The control location returns the switches and a write resets done.
// - A write to one location starts the watchdog, to another stops it.
// - The 5 V and 15 V supply good inputs read as status bits.
// - The status byte has serial and strobe bit positions forced to zero.
// - A bus reset command drives a 100 ms clear pulse onto the bus only.
// - An enabled watchdog resets all on bus silence of 1 or 10 s, off at reset.
module pbh_host_port import pbh_pkg::*; #(
    parameter int unsigned CLR_CYC = `PBH_CLR_CYC,
    parameter longint unsigned WD_SHORT_CYC = `PBH_WD_SHORT_CYC,
    parameter longint unsigned WD_LONG_CYC = `PBH_WD_LONG_CYC
) (
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    input wire logic CPU_RD_I,
    input wire logic CPU_WR_I,
    input wire logic CPU_PORT_I,
    input wire logic [15:0] CPU_ADDR_I,
    input wire logic [7:0] CPU_WDATA_I,
    output logic [7:0] CPU_RDATA_O,
    output logic CPU_ACK_O,
    input wire logic CMD_VALID_I,
    input wire logic CMD_WRITE_I,
    input wire logic [31:0] CMD_ARG_I,
    input wire logic [7:0] CMD_WDATA_I,
    input wire logic BUS_RESET_I,
    input wire logic WD_LONG_I,
    output logic CMD_BUSY_O,
    output logic CMD_DONE_O,
    output logic CMD_ERR_O,
    output logic [7:0] CMD_RDATA_O,
    output logic SYS_RESET_O,
    output logic [5:0] MB_ADDR_O,
    output logic [7:0] MB_DATA_O,
    output logic MB_DATA_OE_N_O,
    input wire logic [7:0] MB_DATA_I,
    output logic MB_RW_O,
    output logic MB_WSTRB_N_O,
    output logic MB_CLEAR_N_O,
    input wire logic MB_BUSY_N_I,
    input wire logic [7:0] DIP_SW_I,
    input wire logic PWR5_OK_I,
    input wire logic PWR15_OK_I,
    input wire logic [1:0] SPARE_IN_I,
    output logic SPARE_OUT_O
);
    localparam int SETTLE_N = `PBH_SETTLE_CYC;
    localparam int SETTLE_M = SETTLE_N + 2;
    localparam int NS = 21;
    localparam logic [7:0] SET_C = 8'(`PBH_SETTLE_CYC);
    localparam logic [7:0] STRB_C = 8'(`PBH_STRB_CYC);
    // ==========================================================
    // Pin synchronisers; a bit moves once stages two and three agree
    logic [NS-1:0] pin_raw, s1_q, s2_q, s3_q, st_q;
    assign pin_raw = {MB_BUSY_N_I, PWR5_OK_I, PWR15_OK_I, SPARE_IN_I,
                      DIP_SW_I, MB_DATA_I};
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge MCLK_I) begin
                if (SYS_RST_I) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    st_q[gi] <= 1'b0;
                end else if (CE_I) begin
                    s1_q[gi] <= pin_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        st_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate
    logic busy_n_s, pwr5_s, pwr15_s;
    logic [1:0] spare_s;
    logic [7:0] dip_s, data_s;
    assign {busy_n_s, pwr5_s, pwr15_s, spare_s, dip_s, data_s} = st_q;
    // ==========================================================
    // Processor side decode
    logic win_hit, rd_win, wr_win, wr_wdone, wr_wd_on, wr_wd_off;
    logic wr_ctrl, rd_ctrl, rd_stat, rd_sw, cmd_ok, cmd_bad;
    pbh_state_e st_q_e;
    assign win_hit = !CPU_PORT_I &&
                     ((CPU_ADDR_I & `PBH_WIN_MASK) == `PBH_WIN_BASE);
    assign rd_win = CE_I && CPU_RD_I && win_hit;
    assign wr_win = CE_I && CPU_WR_I && win_hit;
    assign rd_sw = CPU_RD_I && !CPU_PORT_I && CPU_ADDR_I == `PBH_SW_WDONE;
    assign wr_wdone = CE_I && CPU_WR_I && !CPU_PORT_I &&
                      CPU_ADDR_I == `PBH_SW_WDONE;
    assign wr_wd_on = CE_I && CPU_WR_I && !CPU_PORT_I &&
                      CPU_ADDR_I == `PBH_WD_ON;
    assign wr_wd_off = CE_I && CPU_WR_I && !CPU_PORT_I &&
                       CPU_ADDR_I == `PBH_WD_OFF;
    assign wr_ctrl = CE_I && CPU_WR_I && CPU_PORT_I &&
                     CPU_ADDR_I == `PBH_PORT_CTRL;
    assign rd_ctrl = CPU_RD_I && CPU_PORT_I && CPU_ADDR_I == `PBH_PORT_CTRL;
    assign rd_stat = CPU_RD_I && CPU_PORT_I && CPU_ADDR_I == `PBH_PORT_STAT;
    // A window access in the same cycle keeps the request waiting
    assign cmd_ok = CE_I && CMD_VALID_I && st_q_e == PBH_IDLE &&
                    !wr_win && !rd_win && CMD_ARG_I <= `PBH_ARG_MAX;
    assign cmd_bad = CE_I && CMD_VALID_I && st_q_e == PBH_IDLE &&
                     !wr_win && !rd_win && CMD_ARG_I > `PBH_ARG_MAX;
    // ==========================================================
    // Bus cycle sequencer
    logic [5:0] addr_q;
    logic [7:0] data_q, cnt_q, p1_q;
    logic wr_q, chk_q, rw_q, rw_set, rw_clr, wd_trip, clr_active;
    assign rw_set = st_q_e == PBH_SETTLE && cnt_q == 8'h00 && wr_q ||
                    st_q_e == PBH_IDLE && wr_win;
    assign rw_clr = wr_wdone || !MB_CLEAR_N_O ||
                    st_q_e == PBH_FINISH && busy_n_s;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            st_q_e <= PBH_IDLE;
            addr_q <= 6'h00;
            data_q <= 8'h00;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            chk_q <= 1'b0;
        end else if (CE_I) begin
            unique case (st_q_e)
                PBH_IDLE: begin
                    if (wr_win) begin
                        addr_q <= CPU_ADDR_I[5:0];
                        data_q <= CPU_WDATA_I;
                        wr_q <= 1'b1;
                        chk_q <= 1'b0;
                        cnt_q <= STRB_C;
                        st_q_e <= PBH_STROBE;
                    end else if (rd_win) begin
                        addr_q <= CPU_ADDR_I[5:0];
                    end else if (cmd_ok) begin
                        addr_q <= CMD_ARG_I[5:0];
                        data_q <= CMD_WDATA_I;
                        wr_q <= CMD_WRITE_I;
                        chk_q <= 1'b1;
                        st_q_e <= PBH_WAIT_DONE;
                    end
                end
                PBH_WAIT_DONE: begin
                    if (!rw_q) begin
                        cnt_q <= SET_C;
                        st_q_e <= PBH_SETTLE;
                    end
                end
                PBH_SETTLE: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else if (wr_q) begin
                        cnt_q <= STRB_C;
                        st_q_e <= PBH_STROBE;
                    end else begin
                        st_q_e <= PBH_IDLE;
                    end
                end
                PBH_STROBE: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        st_q_e <= PBH_FINISH;
                    end
                end
                PBH_FINISH: begin
                    if (busy_n_s || !MB_CLEAR_N_O) begin
                        st_q_e <= PBH_IDLE;
                    end
                end
            endcase
        end
    end
    // Set wins over every clear source
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            rw_q <= 1'b0;
        end else if (CE_I) begin
            if (rw_set) begin
                rw_q <= 1'b1;
            end else if (rw_clr) begin
                rw_q <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Bus pins, all registered
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            MB_ADDR_O <= 6'h00;
            MB_DATA_O <= 8'h00;
            MB_DATA_OE_N_O <= 1'b1;
            MB_WSTRB_N_O <= 1'b1;
            MB_RW_O <= 1'b0;
        end else if (CE_I) begin
            MB_RW_O <= rw_set || (rw_q && !rw_clr);
            if (st_q_e == PBH_IDLE && (wr_win || rd_win)) begin
                MB_ADDR_O <= CPU_ADDR_I[5:0];
            end else if (st_q_e == PBH_WAIT_DONE && !rw_q) begin
                MB_ADDR_O <= addr_q;
            end
            MB_DATA_O <= data_q;
            // Host drives data only while strobing a write
            MB_DATA_OE_N_O <= !(rw_set || st_q_e == PBH_STROBE &&
                                cnt_q != 8'h00);
            MB_WSTRB_N_O <= !(rw_set || st_q_e == PBH_STROBE &&
                              cnt_q != 8'h00);
            if (st_q_e == PBH_IDLE && wr_win) begin
                MB_DATA_O <= CPU_WDATA_I;
            end else if (st_q_e == PBH_IDLE && cmd_ok) begin
                MB_DATA_O <= CMD_WDATA_I;
            end
        end
    end
    // ==========================================================
    // Command answers
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            CMD_DONE_O <= 1'b0;
            CMD_ERR_O <= 1'b0;
            CMD_RDATA_O <= 8'h00;
            CMD_BUSY_O <= 1'b0;
        end else if (CE_I) begin
            CMD_ERR_O <= cmd_bad;
            CMD_BUSY_O <= cmd_ok || wr_win ||
                          (st_q_e != PBH_IDLE && !(CMD_DONE_O || 1'b0));
            CMD_DONE_O <= chk_q && (st_q_e == PBH_SETTLE && cnt_q == 8'h00 &&
                          !wr_q || st_q_e == PBH_FINISH &&
                          (busy_n_s || !MB_CLEAR_N_O));
            if (st_q_e == PBH_SETTLE && cnt_q == 8'h00 && !wr_q) begin
                CMD_RDATA_O <= data_s;
            end
        end
    end
    // ==========================================================
    // Processor read data and control port
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            CPU_RDATA_O <= 8'h00;
            CPU_ACK_O <= 1'b0;
            p1_q <= `PBH_P1_RESET;
        end else if (CE_I) begin
            CPU_ACK_O <= CPU_RD_I || CPU_WR_I;
            if (wr_ctrl) begin
                p1_q <= CPU_WDATA_I;
            end
            CPU_RDATA_O <= 8'h00;
            if (CPU_RD_I && win_hit) begin
                // Data from the address set by an earlier access
                CPU_RDATA_O <= data_s;
            end else if (rd_sw) begin
                CPU_RDATA_O <= dip_s;
            end else if (rd_ctrl) begin
                CPU_RDATA_O[`PBH_P1_BUSY] <= busy_n_s;
                CPU_RDATA_O[`PBH_P1_RW] <= rw_q;
                CPU_RDATA_O[`PBH_P1_SPARE] <= p1_q[`PBH_P1_SPARE];
                CPU_RDATA_O[`PBH_P1_CLEAR] <= p1_q[`PBH_P1_CLEAR];
            end else if (rd_stat) begin
                // Serial and strobe positions stay at the zero default
                CPU_RDATA_O[`PBH_P3_PWR5] <= pwr5_s;
                CPU_RDATA_O[`PBH_P3_PWR15] <= pwr15_s;
                CPU_RDATA_O[`PBH_P3_SPR3] <= spare_s[1];
                CPU_RDATA_O[`PBH_P3_SPR5] <= spare_s[0];
            end
        end
    end
    // ==========================================================
    // Bus clear pulse and watchdog
    logic [31:0] clr_cnt_q;
    logic [63:0] wd_cnt_q, wd_lim;
    logic wd_en_q, bus_act;
    assign clr_active = clr_cnt_q != 32'h0;
    assign bus_act = rw_set || st_q_e == PBH_SETTLE || rd_win;
    assign wd_lim = WD_LONG_I ? 64'(WD_LONG_CYC) : 64'(WD_SHORT_CYC);
    assign wd_trip = wd_en_q && wd_cnt_q >= wd_lim;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            clr_cnt_q <= 32'h0;
            MB_CLEAR_N_O <= 1'b1;
            SPARE_OUT_O <= 1'b1;
        end else if (CE_I) begin
            if (BUS_RESET_I || wd_trip) begin
                clr_cnt_q <= CLR_CYC;
            end else if (clr_active) begin
                clr_cnt_q <= clr_cnt_q - 32'h1;
            end
            MB_CLEAR_N_O <= p1_q[`PBH_P1_CLEAR] && !clr_active;
            SPARE_OUT_O <= p1_q[`PBH_P1_SPARE];
        end
    end
    // Silence is counted from the last bus cycle; trip also disarms
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            wd_en_q <= 1'b0;
            wd_cnt_q <= 64'h0;
            SYS_RESET_O <= 1'b0;
        end else if (CE_I) begin
            SYS_RESET_O <= wd_trip;
            if (wr_wd_on) begin
                wd_en_q <= 1'b1;
            end else if (wr_wd_off || wd_trip) begin
                wd_en_q <= 1'b0;
            end
            if (!wd_en_q || bus_act || wd_trip) begin
                wd_cnt_q <= 64'h0;
            end else begin
                wd_cnt_q <= wd_cnt_q + 64'h1;
            end
        end
    end
    // ==========================================================
    // Checks
    sequence s_read_go;
        st_q_e == PBH_WAIT_DONE && !rw_q && !wr_q && CE_I;
    endsequence
    a_arg_error: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        cmd_bad |=> CMD_ERR_O && st_q_e == PBH_IDLE)
        else $error("oversize argument not refused");
    a_six_bit_addr: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        cmd_ok |=> addr_q == $past(CMD_ARG_I[5:0]))
        else $error("address not cut to six bits");
    a_wait_write_done: assert property (@(posedge MCLK_I)
        disable iff (SYS_RST_I)
        st_q_e == PBH_WAIT_DONE && rw_q && CE_I |=> st_q_e == PBH_WAIT_DONE)
        else $error("cycle started before write done");
    a_read_settle: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        s_read_go |=> st_q_e == PBH_SETTLE && cnt_q == SET_C)
        else $error("read sampled before settling");
    a_settle_hold: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        st_q_e == PBH_SETTLE && cnt_q != 8'h00 |=>
        st_q_e == PBH_SETTLE)
        else $error("settling cut short");
    a_read_done: assert property (@(posedge MCLK_I)
        disable iff (SYS_RST_I || !CE_I)
        s_read_go |-> ##SETTLE_M chk_q && CMD_DONE_O)
        else $error("checked read did not finish");
    a_strobe_drive: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        !MB_WSTRB_N_O |-> MB_RW_O && !MB_DATA_OE_N_O)
        else $error("strobe without write and data");
    a_raw_no_check: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        st_q_e == PBH_IDLE && wr_win |=> st_q_e == PBH_STROBE)
        else $error("window write was delayed");
    a_stat_mask: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        rd_stat && CE_I |=> CPU_RDATA_O[7:6] == 2'b00 &&
        CPU_RDATA_O[1:0] == 2'b00)
        else $error("masked status bits not zero");
    a_clear_ctl: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        wr_ctrl && !CPU_WDATA_I[0] ##1 CE_I |=> !MB_CLEAR_N_O)
        else $error("clear bit did not reach the bus");
    a_wd_strobes: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        wr_wd_on |=> wd_en_q)
        else $error("watchdog did not start");
endmodule
`default_nettype wire

// ### include/pbh_map.svh
`ifndef PBH_MAP_SVH
`define PBH_MAP_SVH
// ==========================================================
// Memory window and control locations
`define PBH_WIN_BASE 16'h6000
`define PBH_SW_WDONE 16'h6040
`define PBH_WD_ON 16'h6080
`define PBH_WD_OFF 16'h60c0
`define PBH_WIN_MASK 16'hffc0
// ==========================================================
// Port indices, used when CPU_PORT_I is high
`define PBH_PORT_CTRL 16'h0001
`define PBH_PORT_STAT 16'h0003
// ==========================================================
// Field positions
`define PBH_P1_CLEAR 0
`define PBH_P1_SPARE 1
`define PBH_P1_RW 2
`define PBH_P1_BUSY 6
`define PBH_P3_PWR5 2
`define PBH_P3_SPR3 3
`define PBH_P3_PWR15 4
`define PBH_P3_SPR5 5
`define PBH_P1_RESET 8'h03
`define PBH_ARG_MAX 32'h0000ffff
// ==========================================================
// Timing
`define PBH_CLK_NS 5
`define PBH_SETTLE_NS 100
`define PBH_STRB_NS 200
`define PBH_SETTLE_CYC ((`PBH_SETTLE_NS + `PBH_CLK_NS - 1) / `PBH_CLK_NS)
`define PBH_STRB_CYC ((`PBH_STRB_NS + `PBH_CLK_NS - 1) / `PBH_CLK_NS)
`define PBH_CLR_MS 100
`define PBH_CLR_CYC (`PBH_CLR_MS * 1000000 / `PBH_CLK_NS)
`define PBH_WD_SHORT_S 1
`define PBH_WD_LONG_S 10
`define PBH_WD_SHORT_CYC (`PBH_WD_SHORT_S * 1000000000 / `PBH_CLK_NS)
`define PBH_WD_LONG_CYC (`PBH_WD_LONG_S * 64'd1000000000 / `PBH_CLK_NS)
`endif

// ### include/pbh_pkg.sv
package pbh_pkg;
    typedef enum logic [2:0] {
        PBH_IDLE,
        PBH_WAIT_DONE,
        PBH_SETTLE,
        PBH_STROBE,
        PBH_FINISH
    } pbh_state_e;
    typedef logic [7:0] pbh_byte_t;
endpackage

// ### dv/pbh_board_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Boards on the peripheral bus
module pbh_board_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] host_data_i,
    input wire logic host_oe_n_i,
    input wire logic rw_i,
    input wire logic wstrb_n_i,
    input wire logic clear_n_i,
    input wire logic [7:0] hold_i,
    output logic [7:0] bus_data_o,
    output logic busy_n_o
);
    logic [7:0] mem_q [64];
    logic [7:0] last_q;
    logic [7:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !clear_n_i) begin
            for (int i = 0; i < 64; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (!wstrb_n_i && rw_i) begin
            mem_q[addr_i] <= bus_data_o;
        end
    end
    // Slow boards keep busy low for hold_i cycles after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else if (!wstrb_n_i) begin
            cnt_q <= hold_i;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    assign busy_n_o = wstrb_n_i && (cnt_q == 8'h00);
    // Released lines toggle so a stale sample never looks valid
    always_ff @(posedge clk_i) begin
        last_q <= ~bus_data_o;
    end
    always_comb begin
        if (!host_oe_n_i) begin
            bus_data_o = host_data_i;
        end else if (!rw_i) begin
            bus_data_o = mem_q[addr_i];
        end else begin
            bus_data_o = last_q;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbh_map.svh"
module tb_top;
    logic clk, rst, rd, wr, port, cmd_v, cmd_w, bus_rst, wd_long, p5, p15;
    logic [15:0] addr;
    logic [31:0] arg;
    logic [7:0] wdata, cwd, dip, hold, rdata, crd, mb_do, mb_di, q;
    logic [1:0] spare;
    logic [5:0] mb_addr;
    logic ack, busy, done, err, sysrst, oe_n, rw, wstrb_n, clr_n, busy_n;
    logic spare_o, ce;
    int n_errors, samples_checked, n;
    pbh_host_port #(.CLR_CYC(50), .WD_SHORT_CYC(100), .WD_LONG_CYC(300)) dut (
        .MCLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .CPU_RD_I(rd),
        .CPU_WR_I(wr), .CPU_PORT_I(port), .CPU_ADDR_I(addr),
        .CPU_WDATA_I(wdata), .CPU_RDATA_O(rdata), .CPU_ACK_O(ack),
        .CMD_VALID_I(cmd_v), .CMD_WRITE_I(cmd_w), .CMD_ARG_I(arg),
        .CMD_WDATA_I(cwd), .BUS_RESET_I(bus_rst), .WD_LONG_I(wd_long),
        .CMD_BUSY_O(busy), .CMD_DONE_O(done), .CMD_ERR_O(err),
        .CMD_RDATA_O(crd), .SYS_RESET_O(sysrst), .MB_ADDR_O(mb_addr),
        .MB_DATA_O(mb_do), .MB_DATA_OE_N_O(oe_n), .MB_DATA_I(mb_di),
        .MB_RW_O(rw), .MB_WSTRB_N_O(wstrb_n), .MB_CLEAR_N_O(clr_n),
        .MB_BUSY_N_I(busy_n), .DIP_SW_I(dip), .PWR5_OK_I(p5),
        .PWR15_OK_I(p15), .SPARE_IN_I(spare), .SPARE_OUT_O(spare_o));
    pbh_board_model board (.clk_i(clk), .rst_i(rst), .addr_i(mb_addr),
        .host_data_i(mb_do), .host_oe_n_i(oe_n), .rw_i(rw),
        .wstrb_n_i(wstrb_n), .clear_n_i(clr_n), .hold_i(hold),
        .bus_data_o(mb_di), .busy_n_o(busy_n));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    task automatic end_sim();
        $display("Checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        end_sim();
    endtask
    task automatic cpu(input logic p, input logic w, input logic [15:0] a,
            input logic [7:0] d);
        @(posedge clk) #1;
        port = p;
        addr = a;
        wdata = d;
        rd = !w;
        wr = w;
        @(posedge clk) #1;
        rd = 1'b0;
        wr = 1'b0;
        check(ack, 1'b1);
        q = rdata;
    endtask
    task automatic cmd(input logic w, input logic [31:0] a,
            input logic [7:0] d, input logic e);
        // A request made while the sequencer is busy would be ignored
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge clk) #1;
            if (++n > 2000) hang();
        end
        @(posedge clk) #1;
        cmd_v = 1'b1;
        cmd_w = w;
        arg = a;
        cwd = d;
        @(posedge clk) #1;
        cmd_v = 1'b0;
        check(busy, !e);
        n = 0;
        while (done !== 1'b1 && err !== 1'b1) begin
            @(posedge clk) #1;
            n++;
            if (n > 2000) hang();
        end
        check(err, e);
        check(done, !e);
    endtask
    task automatic wait_rw();
        n = 0;
        q = 8'h04;
        while (q[2] !== 1'b0) begin
            cpu(1'b1, 1'b0, `PBH_PORT_CTRL, 8'h00);
            if (++n > 300) hang();
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {rst, rd, wr, port, cmd_v, cmd_w, bus_rst, wd_long} = 8'h80;
        {addr, arg, wdata, cwd, hold, spare} = '0;
        {dip, p5, p15} = {8'h96, 2'b11};
        ce = 1'b1;
        n_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check({clr_n, rw, wstrb_n, oe_n, sysrst, spare_o}, 6'h2d);
        cpu(1'b1, 1'b0, `PBH_PORT_CTRL, 8'h00);
        check(q, 8'h43);
        for (int i = 0; i < 16; i++) begin
            {spare, p15, p5} = i[3:0];
            dip = {i[3:0], ~i[3:0]};
            repeat (6) @(posedge clk);
            cpu(1'b1, 1'b0, `PBH_PORT_STAT, 8'h00);
            check(q, {2'b00, spare[0], p15, spare[1], p5, 2'b00});
            cpu(1'b0, 1'b0, `PBH_SW_WDONE, 8'h00);
            check(q, dip);
        end
        // Checked cycles, upper argument bits dropped, back to back
        cmd(1'b1, 32'h0000ffe5, 8'ha7, 1'b0);
        check(mb_addr, 6'h25);
        cmd(1'b1, 32'h0000ffe6, 8'h3c, 1'b0);
        cmd(1'b0, 32'h00000025, 8'h00, 1'b0);
        check(crd, 8'ha7);
        cmd(1'b0, 32'h0000ffa6, 8'h00, 1'b0);
        check(crd, 8'h3c);
        cmd(1'b0, 32'h00010025, 8'h00, 1'b1);
        cmd(1'b1, 32'hffffffff, 8'h55, 1'b1);
        check(mb_addr, 6'h26);
        // Window writes then double reads
        for (int i = 0; i < 2; i++) begin
            cpu(1'b0, 1'b1, `PBH_WIN_BASE + 16'h0020 + i[15:0], 8'h5a + i[7:0]);
            check({mb_addr, wstrb_n, oe_n, rw}, {6'h20 + i[5:0], 3'b001});
            wait_rw();
        end
        for (int i = 0; i < 2; i++) begin
            cpu(1'b0, 1'b0, `PBH_WIN_BASE + 16'h0020 + i[15:0], 8'h00);
            repeat (5) @(posedge clk);
            cpu(1'b0, 1'b0, `PBH_WIN_BASE + 16'h0020 + i[15:0], 8'h00);
            check(q, 8'h5a + i[7:0]);
        end
        // Slow boards: checked read must wait for the write to finish
        hold = 8'd60;
        cpu(1'b0, 1'b1, `PBH_WIN_BASE + 16'h0030, 8'h11);
        cmd(1'b0, 32'h00000030, 8'h00, 1'b0);
        check(crd, 8'h11);
        hold = 8'd200;
        cpu(1'b0, 1'b1, `PBH_WIN_BASE + 16'h0010, 8'h22);
        repeat (60) @(posedge clk);
        cpu(1'b1, 1'b0, `PBH_PORT_CTRL, 8'h00);
        check(q, 8'h07);
        cpu(1'b0, 1'b1, `PBH_SW_WDONE, 8'h00);
        cpu(1'b1, 1'b0, `PBH_PORT_CTRL, 8'h00);
        check(q, 8'h03);
        repeat (220) @(posedge clk);
        hold = 8'd0;
        // Control port drives clear and spare
        cpu(1'b1, 1'b1, `PBH_PORT_CTRL, 8'h02);
        repeat (2) @(posedge clk);
        check({clr_n, spare_o}, 2'b01);
        cpu(1'b1, 1'b1, `PBH_PORT_CTRL, 8'h01);
        repeat (2) @(posedge clk);
        check({clr_n, spare_o}, 2'b10);
        cpu(1'b1, 1'b1, `PBH_PORT_CTRL, 8'h03);
        // Bus-only clear pulse
        @(posedge clk) #1 bus_rst = 1'b1;
        @(posedge clk) #1 bus_rst = 1'b0;
        // Clock enable low for ten cycles freezes the pulse counter
        n = 0;
        repeat (70) begin
            @(posedge clk) #1;
            n += int'(clr_n === 1'b0);
            ce = !(n >= 20 && n < 30);
            if (sysrst !== 1'b0) hang();
        end
        ce = 1'b1;
        check(n, 60);
        // Watchdog stop, then timeouts in both periods
        cpu(1'b0, 1'b1, `PBH_WD_ON, 8'h00);
        cpu(1'b0, 1'b1, `PBH_WD_OFF, 8'h5a);
        n = 0;
        repeat (400) begin
            @(posedge clk) #1;
            n += int'(sysrst === 1'b1);
        end
        check(n, 0);
        for (int m = 0; m < 2; m++) begin
            wd_long = m[0];
            cpu(1'b0, 1'b1, `PBH_WD_ON, 8'hff);
            n = 0;
            while (sysrst !== 1'b1) begin
                @(posedge clk) #1;
                if (++n > 1000) hang();
            end
            check(n > (m ? 290 : 90) && n < (m ? 310 : 110), 1'b1);
            @(posedge clk) #1;
            check(clr_n, 1'b0);
            repeat (100) @(posedge clk);
        end
        end_sim();
    end
endmodule
`default_nettype wire
